// ==== src/bus_condition_detect.sv ====
// start, stop and clock edge detection on the two-wire bus
// assumes scl and sda inputs already synchronous to core_clk
`timescale 1ns/100ps
`default_nettype none

module bus_condition_detect (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      scl_rise,
    output logic      scl_fall,
    output logic      start_det,
    output logic      stop_det
);

    logic scl_ff;
    logic sda_ff;
    logic nxt_scl;
    logic nxt_sda;

    // previous line levels
    always_comb begin
        nxt_scl = scl_in;
        nxt_sda = sda_in;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
        end else begin
            scl_ff <= nxt_scl;
            sda_ff <= nxt_sda;
        end
    end

    // edges and conditions: sda moving while scl stays high
    assign scl_rise  = scl_in & ~scl_ff;
    assign scl_fall  = ~scl_in & scl_ff;
    assign start_det = scl_in & scl_ff & sda_ff & ~sda_in;
    assign stop_det  = scl_in & scl_ff & ~sda_ff & sda_in;

endmodule : bus_condition_detect

`default_nettype wire

// ==== src/pcd_defines.svh ====
// constants for the port change detect block
// assumes inclusion by bare name from the design modules
`ifndef PCD_DEFINES_SVH
`define PCD_DEFINES_SVH

// fixed upper bits of the 7-bit target address
`define ADDR_UPPER_BITS   3'h6
// open-drain i/o ports sit at bits 5..2 of the port byte
`define OD_PORT_MASK      8'h3C
`define OD_LSB            2
// push-pull ports at bits 7..6 and 1..0
`define PP_HI_LSB         6
`define PP_LO_LSB         0
// all outputs high (open-drain released) after reset
`define OUT_RESET         8'hFF
// pullup configuration shown before it may be trusted
`define PULLUP_RESET      2'h0
// bits per byte, counted on the bus clock
`define BYTE_BITS         4'h8
`define LAST_TX_BIT       4'h7

`endif

// ==== src/pcd_pkg.sv ====
// types shared by the port change detect modules
// assumes pcd_defines.svh on the include path
package pcd_pkg;

    // target engine states, gray coded along address -> read path
    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_ADDR     = 3'h1,
        ST_ADDR_ACK = 3'h3,
        ST_RD_DATA  = 3'h2,
        ST_RD_ACK   = 3'h6,
        ST_WR_DATA  = 3'h7,
        ST_WR_ACK   = 3'h5
    } bus_state_type;

    // wiring of one address-select pin
    typedef enum logic [1:0] {
        SEL_GND = 2'h0,
        SEL_VDD = 2'h1,
        SEL_SDA = 2'h2,
        SEL_SCL = 2'h3
    } sel_code_type;

endpackage : pcd_pkg

// ==== src/port_change_detect_alert.sv ====
// port expander core: two-wire target, output byte, change flags and alert
// assumes all pins are synchronous to core_clk, 25 MHz; pins modelled as
// input, output and output enable; address-select wiring arrives as codes
//
// Function
// - With both select pins on supply or ground the pullup setting is right from two clock cycles after reset onward.
// - With a select pin on a bus line the pullup setting may be the default until the first bus start.
// - Each open-drain port used as input is watched against the level taken at the last access.
// - Snapshot and live inputs are compared constantly and any difference drives the alert low outside a read.
// - A difference sets a flag belonging to that port alone.
// - At the acknowledge of each access the ports are resampled and the old flags cleared.
// - A two-byte read returns port levels and then the previous flags.
// - Longer reads keep alternating level bytes and flag bytes until stop.
// - A long read resamples and clears the flags once per byte pair.
// - Changes during a long read show in later flag bytes or through the alert.
// - The alert stays off during a read and a pending change asserts it at stop.
// - No alert at stop when the changed data already went to the master.
// - One written byte sets all push-pull and open-drain outputs together.
// - Acknowledging the own address releases the alert and clears the flags.
// - The target address is 1,1,0 followed by four bits from the select pins.
// - Port data is sampled in the acknowledge before each returned level byte.
`timescale 1ns/100ps
`default_nettype none
`include "pcd_defines.svh"

module port_change_detect_alert
    import pcd_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic [1:0] addr_select_low_pin,
    input  wire logic [1:0] addr_select_high_pin,
    input  wire logic [7:0] port_in,
    output logic      [1:0] pp_hi_out,
    output logic      [1:0] pp_lo_out,
    output logic      [3:0] od_out,
    output logic      [3:0] od_oe,
    output logic            alert_out,
    output logic            alert_oe,
    output logic      [1:0] pullup_en
);

    // bus conditions
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    bus_condition_detect u_cond (
        .core_clk  (core_clk),
        .rst       (rst),
        .scl_in    (scl_in),
        .sda_in    (sda_in),
        .scl_rise  (scl_rise),
        .scl_fall  (scl_fall),
        .start_det (start_det),
        .stop_det  (stop_det)
    );

    // change monitor
    logic       resample;
    logic [7:0] flags;
    logic [7:0] flags_held;

    transition_monitor #(
        .WIDTH (8),
        .MASK  (`OD_PORT_MASK)
    ) u_mon (
        .core_clk   (core_clk),
        .rst        (rst),
        .port_in    (port_in),
        .resample   (resample),
        .flags      (flags),
        .flags_held (flags_held)
    );

    // own address from the select pin wiring
    logic [6:0] own_addr;
    assign own_addr = {`ADDR_UPPER_BITS, addr_select_high_pin, addr_select_low_pin};

    // engine state
    bus_state_type state_ff;
    bus_state_type nxt_state;
    logic [3:0]    cnt_ff;
    logic [3:0]    nxt_cnt;
    logic [7:0]    shift_ff;
    logic [7:0]    nxt_shift;
    logic [7:0]    tx_ff;
    logic [7:0]    nxt_tx;
    logic          sda_oe_ff;
    logic          nxt_sda_oe;
    logic          rw_ff;
    logic          nxt_rw;
    logic          flag_next_ff;
    logic          nxt_flag_next;
    logic          reading_ff;
    logic          nxt_reading;
    logic [7:0]    out_ff;
    logic [7:0]    nxt_out;
    logic [3:0]    od_oe_ff;
    logic [3:0]    nxt_od_oe;
    logic          addr_ack_rise;

    localparam logic [7:0] OUT_INIT = `OUT_RESET;

    // byte engine: address, acknowledge, read and write data
    always_comb begin
        nxt_state     = state_ff;
        nxt_cnt       = cnt_ff;
        nxt_shift     = shift_ff;
        nxt_tx        = tx_ff;
        nxt_sda_oe    = sda_oe_ff;
        nxt_rw        = rw_ff;
        nxt_flag_next = flag_next_ff;
        nxt_reading   = reading_ff;
        nxt_out       = out_ff;
        resample      = 1'b0;
        addr_ack_rise = 1'b0;
        if (start_det) begin
            nxt_state  = ST_ADDR;
            nxt_cnt    = 4'h0;
            nxt_sda_oe = 1'b0;
        end else if (stop_det) begin
            nxt_state   = ST_IDLE;
            nxt_sda_oe  = 1'b0;
            nxt_reading = 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    nxt_sda_oe = 1'b0;
                end
                ST_ADDR, ST_WR_DATA: begin
                    if (scl_rise) begin
                        nxt_shift = {shift_ff[6:0], sda_in};
                        nxt_cnt   = cnt_ff + 4'h1;
                    end else if (scl_fall && cnt_ff == `BYTE_BITS) begin
                        nxt_cnt = 4'h0;
                        if (state_ff == ST_WR_DATA) begin
                            nxt_state  = ST_WR_ACK;
                            nxt_sda_oe = 1'b1;
                        end else if (shift_ff[7:1] == own_addr) begin
                            nxt_state  = ST_ADDR_ACK;
                            nxt_sda_oe = 1'b1;
                            nxt_rw     = shift_ff[0];
                        end else begin
                            nxt_state = ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_rise) begin
                        // every access: resample, clear flags, release alert
                        addr_ack_rise = 1'b1;
                        resample      = 1'b1;
                        nxt_tx        = port_in;
                        nxt_flag_next = 1'b1;
                        nxt_reading   = rw_ff;
                    end else if (scl_fall) begin
                        nxt_cnt = 4'h0;
                        if (rw_ff) begin
                            nxt_state  = ST_RD_DATA;
                            nxt_sda_oe = ~tx_ff[7];
                        end else begin
                            nxt_state  = ST_WR_DATA;
                            nxt_sda_oe = 1'b0;
                        end
                    end
                end
                ST_RD_DATA: begin
                    if (scl_fall) begin
                        if (cnt_ff == `LAST_TX_BIT) begin
                            nxt_state  = ST_RD_ACK;
                            nxt_sda_oe = 1'b0;
                        end else begin
                            nxt_cnt    = cnt_ff + 4'h1;
                            nxt_tx     = {tx_ff[6:0], 1'b0};
                            nxt_sda_oe = ~tx_ff[6];
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise) begin
                        if (sda_in) begin
                            // master ends the read; wait for stop
                            nxt_state = ST_IDLE;
                        end else if (flag_next_ff) begin
                            nxt_tx        = flags_held;
                            nxt_flag_next = 1'b0;
                        end else begin
                            resample      = 1'b1;
                            nxt_tx        = port_in;
                            nxt_flag_next = 1'b1;
                        end
                    end else if (scl_fall) begin
                        nxt_state  = ST_RD_DATA;
                        nxt_cnt    = 4'h0;
                        nxt_sda_oe = ~tx_ff[7];
                    end
                end
                ST_WR_ACK: begin
                    if (scl_rise) begin
                        nxt_out = shift_ff;
                    end else if (scl_fall) begin
                        nxt_state  = ST_WR_DATA;
                        nxt_sda_oe = 1'b0;
                    end
                end
                default: begin
                    nxt_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_ff     <= ST_IDLE;
            cnt_ff       <= 4'h0;
            shift_ff     <= 8'h00;
            tx_ff        <= 8'h00;
            sda_oe_ff    <= 1'b0;
            rw_ff        <= 1'b0;
            flag_next_ff <= 1'b0;
            reading_ff   <= 1'b0;
            out_ff       <= `OUT_RESET;
        end else begin
            state_ff     <= nxt_state;
            cnt_ff       <= nxt_cnt;
            shift_ff     <= nxt_shift;
            tx_ff        <= nxt_tx;
            sda_oe_ff    <= nxt_sda_oe;
            rw_ff        <= nxt_rw;
            flag_next_ff <= nxt_flag_next;
            reading_ff   <= nxt_reading;
            out_ff       <= nxt_out;
        end
    end

    // open-drain enables in their own flops, so no inverter sits before the pins
    always_comb begin
        nxt_od_oe = ~nxt_out[`OD_LSB +: 4];
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            od_oe_ff <= ~OUT_INIT[`OD_LSB +: 4];
        end else begin
            od_oe_ff <= nxt_od_oe;
        end
    end

    // alert: live flags drive it, held off while a read runs
    logic alert_ff;
    logic nxt_alert;

    always_comb begin
        if (addr_ack_rise) begin
            nxt_alert = 1'b0;
        end else begin
            // flags left at stop are changes not yet sent in a level byte
            nxt_alert = (|flags) & ~reading_ff;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            alert_ff <= 1'b0;
        end else begin
            alert_ff <= nxt_alert;
        end
    end

    // pullup setting from the select wiring
    logic       rails_only;
    logic       pull_ok_ff;
    logic       nxt_pull_ok;
    logic [1:0] pullup_ff;
    logic [1:0] nxt_pullup;
    logic       first_ff;
    logic       nxt_first;

    assign rails_only = ~addr_select_high_pin[1] & ~addr_select_low_pin[1];

    always_comb begin
        nxt_first   = 1'b0;
        // rail straps apply right after reset, bus straps after a start
        nxt_pull_ok = pull_ok_ff | (first_ff & rails_only) | start_det;
        nxt_pullup  = pull_ok_ff ? {addr_select_high_pin[0], addr_select_low_pin[0]}
                                 : `PULLUP_RESET;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            first_ff   <= 1'b1;
            pull_ok_ff <= 1'b0;
            pullup_ff  <= `PULLUP_RESET;
        end else begin
            first_ff   <= nxt_first;
            pull_ok_ff <= nxt_pull_ok;
            pullup_ff  <= nxt_pullup;
        end
    end

    // pin drive, all from flip-flops; open-drain pins only pull low
    logic drive_low_ff;

    always_ff @(posedge core_clk) begin
        drive_low_ff <= 1'b0;
    end

    assign sda_out   = drive_low_ff;
    assign sda_oe    = sda_oe_ff;
    assign pp_hi_out = out_ff[`PP_HI_LSB +: 2];
    assign pp_lo_out = out_ff[`PP_LO_LSB +: 2];
    assign od_out    = {4{drive_low_ff}};
    assign od_oe     = od_oe_ff;
    assign alert_out = drive_low_ff;
    assign alert_oe  = alert_ff;
    assign pullup_en = pullup_ff;

endmodule : port_change_detect_alert

`default_nettype wire

// ==== src/transition_monitor.sv ====
// snapshot register and per-port transition flags
// assumes resample is a one-cycle pulse from the bus engine
`timescale 1ns/100ps
`default_nettype none
`include "pcd_defines.svh"

module transition_monitor #(
    parameter int         WIDTH = 8,
    parameter logic [7:0] MASK  = `OD_PORT_MASK
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] port_in,
    input  wire logic             resample,
    output logic      [WIDTH-1:0] flags,
    output logic      [WIDTH-1:0] flags_held
);

    logic [WIDTH-1:0] snap_ff;
    logic [WIDTH-1:0] flag_ff;
    logic [WIDTH-1:0] held_ff;
    logic [WIDTH-1:0] nxt_snap;
    logic [WIDTH-1:0] nxt_flag;
    logic [WIDTH-1:0] nxt_held;

    // per bit: only monitored ports compare, others stay zero
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            if (MASK[i]) begin : g_mon
                always_comb begin
                    // snapshot takes the live level, so a change now is kept
                    nxt_snap[i] = resample ? port_in[i] : snap_ff[i];
                    nxt_held[i] = resample ? (flag_ff[i] | (port_in[i] ^ snap_ff[i]))
                                           : held_ff[i];
                    nxt_flag[i] = resample ? 1'b0
                                           : (flag_ff[i] | (port_in[i] ^ snap_ff[i]));
                end
            end else begin : g_fixed
                always_comb begin
                    nxt_snap[i] = 1'b0;
                    nxt_held[i] = 1'b0;
                    nxt_flag[i] = 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (rst) begin
            snap_ff <= '0;
            flag_ff <= '0;
            held_ff <= '0;
        end else begin
            snap_ff <= nxt_snap;
            flag_ff <= nxt_flag;
            held_ff <= nxt_held;
        end
    end

    assign flags      = flag_ff;
    assign flags_held = held_ff;

endmodule : transition_monitor

`default_nettype wire

// ==== testbench/bus_master_model.sv ====
// two-wire bus master model driving scl and its own side of sda
// assumes sda has a pull-up and the target only pulls it low via sda_oe
`timescale 1ns/100ps
`default_nettype none

module bus_master_model (
    input  wire logic core_clk,
    input  wire logic sda_oe,
    output var  logic scl,
    output var  logic sda_drv
);
    // both lines rest high outside frames
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // half bit; every change lands on a falling clock edge
    task automatic wait_q;
        repeat (4) @(negedge core_clk);
    endtask : wait_q

    // one clock pulse carrying b; s is the wired level while scl is high
    task automatic bit_cycle(input logic b, output logic s);
        sda_drv = b;
        wait_q();
        scl = 1'b1;
        wait_q();
        s = sda_drv & ~sda_oe;
        scl = 1'b0;
    endtask : bit_cycle

    // sda falls while scl is high
    task automatic start_cond;
        sda_drv = 1'b1;
        wait_q();
        scl = 1'b1;
        wait_q();
        sda_drv = 1'b0;
        wait_q();
        scl = 1'b0;
    endtask : start_cond

    // sda rises while scl is high, then the bus rests
    task automatic stop_cond;
        sda_drv = 1'b0;
        wait_q();
        scl = 1'b1;
        wait_q();
        sda_drv = 1'b1;
        wait_q();
    endtask : stop_cond

    // msb first, then the target's acknowledge (0 = taken)
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(d[i], s);
        end
        bit_cycle(1'b1, ack);
    endtask : send_byte

    // msb first; more = 1 acknowledges so the target goes on
    task automatic recv_byte(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, d[i]);
        end
        bit_cycle(~more, s);
    endtask : recv_byte
endmodule : bus_master_model
`default_nettype wire

// ==== testbench/port_change_detect_alert_chk.sv ====
// port-level checks for the port change detect block
// assumes one clock domain, core_clk, with synchronous reset rst
`timescale 1ns/100ps
`default_nettype none

module pcd_alert_chk (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic [1:0] addr_select_low_pin,
    input wire logic [1:0] addr_select_high_pin,
    input wire logic [7:0] port_in,
    input wire logic [1:0] pp_hi_out,
    input wire logic [1:0] pp_lo_out,
    input wire logic [3:0] od_out,
    input wire logic [3:0] od_oe,
    input wire logic       alert_out,
    input wire logic       alert_oe,
    input wire logic [1:0] pullup_en
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    logic [9:0] prev_ff;
    logic [2:0] quiet_ff;
    logic [2:0] nxt_quiet;
    logic       rails;

    // cycles since ports or bus lines last moved, saturating
    always_comb begin
        nxt_quiet = (quiet_ff == 3'h7) ? 3'h7 : quiet_ff + 3'h1;
        if (rst || ({port_in, scl_in, sda_in} != prev_ff)) begin
            nxt_quiet = 3'h0;
        end
    end
    always_ff @(posedge core_clk) begin
        prev_ff  <= {port_in, scl_in, sda_in};
        quiet_ff <= nxt_quiet;
    end
    assign rails = !addr_select_low_pin[1] && !addr_select_high_pin[1];

    a_reset_values: assert property ($fell(rst) |-> pp_hi_out == 2'h3 && pp_lo_out == 2'h3
        && od_oe == 4'h0 && !alert_oe && !sda_oe) else $error("outputs not at reset level");
    a_pullup_rails: assert property (rails && !$past(rst) && !$past(rst, 2) && !$past(rst, 3)
        |-> pullup_en == {addr_select_high_pin[0], addr_select_low_pin[0]})
        else $error("pullup setting wrong for rail wiring");
    a_drive_low_only: assert property (!sda_out && od_out == 4'h0 && !alert_out)
        else $error("open-drain pin driven high");
    a_sda_steady_high: assert property (scl_in && $past(scl_in) && !$past(rst)
        |-> $stable(sda_oe)) else $error("sda drive changed while scl high");
    a_outputs_on_rise: assert property ($changed({pp_hi_out, pp_lo_out, od_oe})
        && !$past(rst) |-> $past(scl_in)) else $error("outputs changed away from ack");
    a_outputs_quiet: assert property (quiet_ff >= 3'h2
        |-> $stable({pp_hi_out, pp_lo_out, od_oe})) else $error("outputs moved on idle bus");
    a_alert_clear_ack: assert property ($fell(alert_oe) && !$past(rst)
        |-> $past(sda_oe) || $past(sda_oe, 2)) else $error("alert released without ack");
    a_alert_steady: assert property (quiet_ff >= 3'h4 |-> $stable(alert_oe))
        else $error("alert moved with steady inputs");

    c_alert_rise: cover property ($rose(alert_oe));
    c_alert_fall: cover property ($fell(alert_oe));
    c_ack_drive: cover property ($rose(sda_oe));
    c_out_write: cover property ($changed(pp_hi_out));
endmodule : pcd_alert_chk

bind port_change_detect_alert pcd_alert_chk u_chk (.core_clk(core_clk), .rst(rst),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_select_low_pin(addr_select_low_pin), .addr_select_high_pin(addr_select_high_pin),
    .port_in(port_in), .pp_hi_out(pp_hi_out), .pp_lo_out(pp_lo_out), .od_out(od_out),
    .od_oe(od_oe), .alert_out(alert_out), .alert_oe(alert_oe), .pullup_en(pullup_en));
`default_nettype wire

// ==== testbench/port_change_detect_alert_tb_top.sv ====
// self-checking bench for the port change detect block
// assumes the bus master model and the bound checker are compiled with it
`timescale 1ns/100ps
`default_nettype none

module port_change_detect_alert_tb_top;
    import pcd_pkg::*;

    localparam int LIMIT = 20000;
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic       scl;
    logic       sda_drv;
    logic       sda_oe;
    logic       sda_out;
    logic [1:0] sel_hi = SEL_VDD;
    logic [1:0] sel_lo = SEL_GND;
    logic [7:0] port_in = 8'hFF;
    logic [1:0] pp_hi_out;
    logic [1:0] pp_lo_out;
    logic [3:0] od_out;
    logic [3:0] od_oe;
    logic       alert_out;
    logic       alert_oe;
    logic [1:0] pullup_en;
    logic [6:0] dev_addr;
    int         n_mismatch = 0;
    int         n_tests = 0;
    int         cycles = 0;
    wire        sda_line = sda_drv & ~sda_oe;

    assign dev_addr = {3'h6, sel_hi, sel_lo};

    // 25 MHz clock
    always #20 core_clk = ~core_clk;

    port_change_detect_alert u_dut (
        .core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_low_pin(sel_lo),
        .addr_select_high_pin(sel_hi), .port_in(port_in), .pp_hi_out(pp_hi_out),
        .pp_lo_out(pp_lo_out), .od_out(od_out), .od_oe(od_oe), .alert_out(alert_out),
        .alert_oe(alert_oe), .pullup_en(pullup_en)
    );

    bus_master_model u_master (
        .core_clk(core_clk), .sda_oe(sda_oe), .scl(scl), .sda_drv(sda_drv)
    );

    // hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    function automatic logic [7:0] out_byte();
        return {pp_hi_out, ~od_oe, pp_lo_out};
    endfunction : out_byte

    // pullups and output levels after reset with rail wiring
    task automatic t_reset;
        repeat (3) @(negedge core_clk);
        check("pullup", {6'h0, sel_hi[0], sel_lo[0]}, {6'h0, pullup_en});
        check("reset out", 8'hFF, out_byte());
    endtask : t_reset

    // two bytes in one write, each applied to all eight outputs
    task automatic t_write;
        logic ack;
        u_master.start_cond();
        u_master.send_byte({dev_addr, 1'b0}, ack);
        check("wr addr ack", 8'h0, {7'h0, ack});
        u_master.send_byte(8'hA5, ack);
        check("out A5", 8'hA5, out_byte());
        u_master.send_byte(8'h5A, ack);
        check("out 5A", 8'h5A, out_byte());
        u_master.stop_cond();
    endtask : t_write

    // foreign addresses, low and fixed upper bits wrong, are not acked
    task automatic t_bad_addr;
        logic ack;
        logic [6:0] flip [2] = '{7'h01, 7'h40};
        foreach (flip[i]) begin
            u_master.start_cond();
            u_master.send_byte({dev_addr ^ flip[i], 1'b1}, ack);
            check("foreign ack", 8'h1, {7'h0, ack});
            u_master.stop_cond();
        end
    endtask : t_bad_addr

    // read of n bytes against expected list, alert held off throughout
    task automatic read_seq(input logic [7:0] exp [4], input int n, input logic [7:0] chg);
        logic ack;
        logic [7:0] d;
        u_master.start_cond();
        u_master.send_byte({dev_addr, 1'b1}, ack);
        check("rd addr ack", 8'h0, {7'h0, ack});
        check("alert at ack", 8'h0, {7'h0, alert_oe});
        for (int i = 0; i < n; i++) begin
            u_master.recv_byte(i < n - 1, d);
            check("read byte", exp[i], d);
            if (i == 0) begin
                port_in = chg;
            end
            check("alert in read", 8'h0, {7'h0, alert_oe});
        end
        u_master.stop_cond();
    endtask : read_seq

    // change before a 2-byte read, another during it: alert deferred to stop
    task automatic t_read2;
        port_in = 8'h77;
        repeat (4) @(negedge core_clk);
        check("alert on change", 8'h1, {7'h0, alert_oe});
        read_seq('{8'h77, 8'h08, 8'h00, 8'h00}, 2, 8'h73);
        check("alert at stop", 8'h1, {7'h0, alert_oe});
    endtask : t_read2

    // long read: change caught in later flag byte, no alert at stop
    task automatic t_long_read;
        read_seq('{8'h73, 8'h04, 8'h53, 8'h20}, 4, 8'h53);
        repeat (4) @(negedge core_clk);
        check("no alert at stop", 8'h0, {7'h0, alert_oe});
    endtask : t_long_read

    // mid-run reset with a select pin on a bus line: default pullups until a start
    task automatic t_bus_strap;
        @(negedge core_clk);
        rst    = 1'b1;
        sel_lo = SEL_SDA;
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        repeat (4) @(negedge core_clk);
        check("pullup before start", 8'h00, {6'h0, pullup_en});
        check("out after reset", 8'hFF, out_byte());
        u_master.start_cond();
        u_master.stop_cond();
        check("pullup after start", {6'h0, sel_hi[0], sel_lo[0]}, {6'h0, pullup_en});
    endtask : t_bus_strap

    task automatic end_of_test;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    // reset, then scenarios in order
    initial begin
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        t_reset();
        t_write();
        t_bad_addr();
        t_read2();
        t_long_read();
        t_bus_strap();
        end_of_test();
    end
endmodule : port_change_detect_alert_tb_top
`default_nettype wire
